// File: core/srs_device.sv
// register-access serial slave: device end of the link
// assumes register contents arrive on plain ports from the rest of chip
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module srs_device (
	// clock and reset
	input  wire logic          sys_clk_i,
	input  wire logic          reset_n_i,
	// chip resets
	input  wire logic          por_active_i,   // power-on reset active
	input  wire logic          wd_reset_i,     // watchdog reset active
	// diagnosis inputs
	input  wire logic          central_failure_bit_i,
	input  wire logic          central_overtemp_bit_i,
	// register file access
	output srs_pkg::srs_addr_t reg_addr_o,     // address under test
	input  wire logic          reg_readable_i, // address may be read
	input  wire logic          reg_writable_i, // address may be written
	input  wire srs_pkg::srs_data_t reg_rdata_i, // content at reg_addr_o
	output logic               reg_we_o,       // one-cycle write pulse
	output srs_pkg::srs_data_t reg_wdata_o,
	output logic               comm_frame_error_flag_o,
	input  wire logic          comm_frame_error_clr_i,
	// link
	srs_if.device              link
);
	import srs_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_DONE} srs_dev_e;

	typedef struct packed {
		srs_dev_e    st;       // evaluation step
		logic        cs_d;     // previous chip select level
		logic        clk_d;    // previous link clock level
		logic [4:0]  cnt;      // clocked bits this frame
		srs_frame_t  rx;       // shifted-in frame
		srs_frame_t  tx;       // response being shifted out
		srs_frame_t  resp;     // response for next frame
		logic        started;  // a rising edge occurred this frame
		logic        sdo;      // output bit
		logic        oe_n;     // output enable, low drives
		logic        wd_d;     // watchdog reset seen last cycle
		logic        we;       // write strobe
		srs_data_t   wdata;    // write data
		logic        comm_frame_error_flag;    // frame error flag
	} srs_dev_s;

	srs_dev_s  r_reg;
	srs_dev_s  r_next;
	logic      cs_s;
	logic      clk_s;
	logic      din_s;
	logic      flag;

	//******************************************************************
	// pin synchronisers
	//******************************************************************
	// chip select idles high: a low start would fake a select edge
	srs_sync #(.RESET_LEVEL(1'b1)) u_cs (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.async_i(link.chip_select_low), .level_o(cs_s));
	srs_sync u_ck (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.async_i(link.serial_clock_pin), .level_o(clk_s));
	srs_sync u_di (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.async_i(link.serial_in_pin), .level_o(din_s));

	// status flag shown before first clock
	assign flag = central_failure_bit_i | central_overtemp_bit_i;

	//******************************************************************
	// frame engine
	//******************************************************************
	always_comb begin
		r_next       = r_reg;
		r_next.cs_d  = cs_s;
		r_next.clk_d = clk_s;
		r_next.wd_d  = wd_reset_i;
		r_next.we    = 1'b0;
		// watchdog reset release selects next answer
		if (r_reg.wd_d && !wd_reset_i) begin
			r_next.resp = {8'h00, ADDR_WD_STATUS, 1'b0};
		end
		if (comm_frame_error_clr_i) begin
			r_next.comm_frame_error_flag = 1'b0;
		end
		// chip select falling: load response, show flag
		if (r_reg.cs_d && !cs_s) begin
			r_next.cnt     = '0;
			r_next.started = 1'b0;
			r_next.tx      = r_reg.resp;
			r_next.sdo     = flag;
		end
		if (!cs_s) begin
			// rising link clock: shift next output bit, lsb first
			if (!r_reg.clk_d && clk_s) begin
				r_next.sdo     = r_reg.started ? r_reg.tx[1] : r_reg.tx[0];
				if (r_reg.started) begin
					r_next.tx = {1'b0, r_reg.tx[15:1]};
				end
				r_next.started = 1'b1;
			end
			// falling link clock: sample input, count bits
			if (r_reg.clk_d && !clk_s) begin
				r_next.rx = {din_s, r_reg.rx[15:1]};
				if (r_reg.cnt != 5'h1f) begin
					r_next.cnt = r_reg.cnt + 5'h01;
				end
			end
		end
		if (wd_reset_i) begin
			r_next.sdo = flag;
		end
		r_next.oe_n = por_active_i;
		// chip select rising ends the frame
		unique case (r_reg.st)
			ST_IDLE: begin
				if (!r_reg.cs_d && cs_s && !wd_reset_i && !por_active_i) begin
					if (r_reg.cnt == 5'(FRAME_BITS)) begin
						r_next.st = ST_LOOK;
					end else begin
						r_next.comm_frame_error_flag = 1'b1;
						r_next.resp  = {8'h00, ADDR_MAIN_DIAG, 1'b0};
					end
				end
			end
			ST_LOOK: begin
				// address presented, permission sampled
				if (r_reg.rx[RW_POS] && reg_writable_i) begin
					r_next.we    = 1'b1;
					r_next.wdata = r_reg.rx[DATA_MSB:DATA_LSB];
					r_next.st    = ST_DONE;
				end else if (!r_reg.rx[RW_POS] && reg_readable_i) begin
					r_next.resp = {reg_rdata_i, r_reg.rx[7:0]};
					r_next.st   = ST_IDLE;
				end else begin
					// wrong direction or unknown address: no access, answer carries zero data
					r_next.resp = {8'h00, r_reg.rx[7:0]};
					r_next.st   = ST_IDLE;
				end
			end
			ST_DONE: begin
				// wait out the write pulse: the register file takes it
				// on the same edge, so its content is new only after it
				if (!r_reg.we) begin
					r_next.resp = {reg_rdata_i, r_reg.rx[7:0]};
					r_next.st   = ST_IDLE;
				end
			end
			default: begin
				// unused code: fall back to idle
				r_next.st = ST_IDLE;
			end
		endcase
	end

	// state register; power-on reset preloads operating status answer
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r_reg      <= '0;
			r_reg.cs_d <= 1'b1;
			r_reg.oe_n <= 1'b1;
			r_reg.resp <= {8'h00, ADDR_OP_STATUS, 1'b0};
		end else if (por_active_i) begin
			r_reg      <= '0;
			r_reg.cs_d <= 1'b1;
			r_reg.oe_n <= 1'b1;
			r_reg.resp <= {8'h00, ADDR_OP_STATUS, 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_addr_o = r_reg.rx[ADDR_MSB:ADDR_LSB];
	assign reg_we_o   = r_reg.we;
	assign reg_wdata_o = r_reg.wdata;
	assign comm_frame_error_flag_o = r_reg.comm_frame_error_flag;
	assign link.sdo_o    = r_reg.sdo;
	assign link.sdo_oe_n = r_reg.oe_n;
endmodule : srs_device
`default_nettype wire

// File: core/srs_pkg.sv
// constants, types and field layout shared by both ends of the serial link
// assumes a 200 MHz system clock on both ends and a 16-bit lsb-first frame
package srs_pkg;

	//******************************************************************
	// frame layout
	//******************************************************************
	localparam int FRAME_BITS = 16;   // bits in one frame
	localparam int RW_POS     = 0;    // read_write_bit position
	localparam int ADDR_LSB   = 1;    // address low bit
	localparam int ADDR_MSB   = 7;    // address high bit
	localparam int DATA_LSB   = 8;    // register_data_field low bit
	localparam int DATA_MSB   = 15;   // register_data_field high bit
	localparam int CNT_W      = 5;    // bit counter width

	typedef logic [15:0] srs_frame_t; // one frame
	typedef logic [6:0]  srs_addr_t;  // register address
	typedef logic [7:0]  srs_data_t;  // register content

	//******************************************************************
	// register addresses of the device answers (plain defaults)
	//******************************************************************
	localparam srs_addr_t ADDR_OP_STATUS   = 7'h01; // operating status
	localparam srs_addr_t ADDR_WD_STATUS   = 7'h02; // func watchdog status
	localparam srs_addr_t ADDR_MAIN_DIAG   = 7'h03; // main diagnosis
	localparam srs_addr_t ADDR_COMM_DIAG   = 7'h04; // comm diagnosis
	localparam int        COMM_FRAME_ERROR_FLAG_POS        = 0;     // error flag in comm diag

	//******************************************************************
	// host register map on apb (byte offsets)
	//******************************************************************
	localparam logic [11:0] OFS_CTRL   = 12'h000; // w: frame, go
	localparam logic [11:0] OFS_STATUS = 12'h004; // r: busy, flag
	localparam logic [11:0] OFS_RX     = 12'h008; // r: last response
	localparam logic [11:0] OFS_CFG    = 12'h00c; // rw: bit count
	localparam logic [4:0]  CFG_RESET  = 5'h10;   // default bit count
	localparam int          GO_POS     = 16;      // go bit in ctrl

	// link clock half period: a reload of 20 gives 21 system cycles, keeping the link under 5 MHz
	localparam int LINK_HALF_NS  = 100;
	localparam int SYS_PERIOD_NS = 5;
	localparam int HALF_CYC      = LINK_HALF_NS / SYS_PERIOD_NS;

	// bit of the frame to use for a given position (lsb first)
	function automatic logic frame_bit(input srs_frame_t f,
		input logic [4:0] idx);
		frame_bit = f[idx[3:0]];
	endfunction : frame_bit

endpackage : srs_pkg

// File: core/srs_if.sv
// serial link between host controller and register slave
// resolves the data-out wire from its enable inside this interface
`timescale 1ns/1ps
`default_nettype none
interface srs_if;
	logic chip_select_low;   // frame select, low active
	logic serial_clock_pin;  // link clock from host
	logic serial_in_pin;     // host to device data
	logic sdo_o;             // device to host data value
	logic sdo_oe_n;          // low while device drives data out
	logic sdo_line;          // resolved level seen by host

	// no pull on this wire: while released it shows the inverse of the
	// last driven value, so a host that reads a released line is caught
	assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o;

	modport device (
		input  chip_select_low, serial_clock_pin, serial_in_pin,
		output sdo_o, sdo_oe_n
	);
	modport host (
		output chip_select_low, serial_clock_pin, serial_in_pin,
		input  sdo_line
	);
endinterface : srs_if
`default_nettype wire

// File: core/srs_sync.sv
// three-stage synchroniser with agreement filter
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module srs_sync #(
	// level that the stages and the output start from
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	// async level in, filtered level out
	input  wire logic async_i,
	output logic      level_o
);
	import srs_pkg::*;

	typedef struct packed {
		logic [2:0] stage; // stage[0] feeds only stage[1]
		logic       level; // accepted level
	} srs_sync_s;

	srs_sync_s s_reg;
	srs_sync_s s_next;

	// shift and accept when last two stages agree
	always_comb begin
		s_next       = s_reg;
		s_next.stage = {s_reg.stage[1:0], async_i};
		if (s_reg.stage[1] == s_reg.stage[2]) begin
			s_next.level = s_reg.stage[2];
		end
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// start at the pin's idle level so reset makes no false edge
			s_reg.stage <= {3{RESET_LEVEL}};
			s_reg.level <= RESET_LEVEL;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level_o = s_reg.level;
endmodule : srs_sync
`default_nettype wire

// File: core/srs_host.sv
// host end: apb-controlled serial master
// assumes an apb master in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module srs_host (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// link
	srs_if.host              link
);
	import srs_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_LO, H_HI, H_END} srs_host_e;

	typedef struct packed {
		srs_host_e  st;
		logic [7:0] div;     // half period counter
		logic [4:0] bits;    // bits left
		logic [4:0] nbits;   // configured bit count
		srs_frame_t tx;      // outgoing frame
		srs_frame_t rx;      // incoming response
		logic       flag;    // status flag seen at select
		logic       cs_n;
		logic       sck;
		logic       mosi;
		logic [31:0] rdata;
	} srs_host_s;

	srs_host_s h_reg;
	srs_host_s h_next;
	logic      sdo_s;
	logic      acc;

	srs_sync u_sdo (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.async_i(link.sdo_line), .level_o(sdo_s));

	assign acc = psel_i & penable_i;

	//******************************************************************
	// apb decode and frame sequencer
	//******************************************************************
	always_comb begin
		h_next = h_reg;
		if (h_reg.div != 8'h00) begin
			h_next.div = h_reg.div - 8'h01;
		end
		// read data, registered for the access phase
		unique case (paddr_i)
			OFS_STATUS: h_next.rdata = {30'h0, h_reg.flag,
				h_reg.st != H_IDLE};
			OFS_RX:     h_next.rdata = {16'h0, h_reg.rx};
			OFS_CFG:    h_next.rdata = {27'h0, h_reg.nbits};
			default:    h_next.rdata = 32'h0;
		endcase
		if (acc && pwrite_i && paddr_i == OFS_CFG) begin
			h_next.nbits = pwdata_i[4:0];
		end
		unique case (h_reg.st)
			H_IDLE: begin
				if (acc && pwrite_i && paddr_i == OFS_CTRL && pwdata_i[GO_POS]) begin
					h_next.tx   = pwdata_i[15:0];
					h_next.bits = h_reg.nbits;
					h_next.cs_n = 1'b0;
					h_next.div  = 8'(HALF_CYC);
					h_next.st   = H_LO;
				end
			end
			H_LO: begin
				if (h_reg.div == 8'h00) begin
					if (h_reg.bits == 5'h00) begin
						h_next.st  = H_END;
						h_next.div = 8'(HALF_CYC);
					end else begin
						// rising: put out next bit lsb first
						if (h_reg.bits == h_reg.nbits) begin
							h_next.flag = sdo_s;
						end
						h_next.sck  = 1'b1;
						h_next.mosi = h_reg.tx[0];
						h_next.tx   = {1'b0, h_reg.tx[15:1]};
						h_next.div  = 8'(HALF_CYC);
						h_next.st   = H_HI;
					end
				end
			end
			H_HI: begin
				if (h_reg.div == 8'h00) begin
					// falling: both sides sample
					h_next.sck  = 1'b0;
					h_next.rx   = {sdo_s, h_reg.rx[15:1]};
					h_next.bits = h_reg.bits - 5'h01;
					h_next.div  = 8'(HALF_CYC);
					h_next.st   = H_LO;
				end
			end
			H_END: begin
				if (h_reg.div == 8'h00) begin
					h_next.cs_n = 1'b1;
					h_next.st   = H_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			h_reg       <= '0;
			h_reg.cs_n  <= 1'b1;
			h_reg.nbits <= CFG_RESET;
		end else begin
			h_reg <= h_next;
		end
	end

	assign prdata_o  = h_reg.rdata;
	assign pready_o  = acc;
	assign pslverr_o = 1'b0;
	assign link.chip_select_low  = h_reg.cs_n;
	assign link.serial_clock_pin = h_reg.sck;
	assign link.serial_in_pin    = h_reg.mosi;
endmodule : srs_host
`default_nettype wire

// File: dv/srs_asserts.sv
// checker for the serial link between host end and device end
// assumes it is instantiated beside the link interface in the bench
`timescale 1ns/1ps
`default_nettype none
module srs_asserts (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// chip state beside the link
	input wire logic por_active_i,
	input wire logic wd_reset_i,
	input wire logic central_failure_bit_i,
	input wire logic central_overtemp_bit_i,
	// link signals
	input wire logic chip_select_low,
	input wire logic serial_clock_pin,
	input wire logic serial_in_pin,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	input wire logic sdo_line
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	//**********************************************************
	// helper logic
	//**********************************************************
	logic       sck_d;      // clock one cycle ago
	logic       seen_rise;  // a rising edge seen in this frame
	logic [3:0] since_rise; // cycles since last rising edge

	// track clock edges inside a frame
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_d      <= 1'b0;
			seen_rise  <= 1'b0;
			since_rise <= 4'hf;
		end else begin
			sck_d <= serial_clock_pin;
			if (chip_select_low)
				seen_rise <= 1'b0;
			else if (serial_clock_pin && !sck_d)
				seen_rise <= 1'b1;
			if (serial_clock_pin && !sck_d)
				since_rise <= 4'h0;
			else if (since_rise != 4'hf)
				since_rise <= since_rise + 4'h1;
		end
	end

	//**********************************************************
	// assertions
	//**********************************************************
	chk_por_tristate: assert property (
		$past(por_active_i) && por_active_i |-> sdo_oe_n)
		else $error("data out driven in power-on reset");
	chk_wd_flag_out: assert property (
		(wd_reset_i && !por_active_i && !chip_select_low)[*8]
		|-> !sdo_oe_n && sdo_line == (central_failure_bit_i
		|| central_overtemp_bit_i))
		else $error("watchdog reset output wrong");
	chk_flag_level: assert property (
		(!chip_select_low && !seen_rise && !por_active_i
		&& $stable(central_failure_bit_i)
		&& $stable(central_overtemp_bit_i))[*8]
		|-> sdo_line == (central_failure_bit_i
		|| central_overtemp_bit_i))
		else $error("status flag level wrong");
	chk_push_pull: assert property (
		(!chip_select_low && !por_active_i)[*8] |-> !sdo_oe_n)
		else $error("data out not driven when selected");
	chk_out_on_rise: assert property (
		$changed(sdo_o) && !chip_select_low && seen_rise
		&& !wd_reset_i && !por_active_i |-> since_rise <= 4'h8)
		else $error("data out moved away from rising edge");
	chk_in_at_fall: assert property (
		$fell(serial_clock_pin) && !chip_select_low
		|-> $stable(serial_in_pin) ##1 $stable(serial_in_pin))
		else $error("data in moved at falling edge");
	chk_end_clk_low: assert property (
		$rose(chip_select_low) |-> !serial_clock_pin)
		else $error("frame ended with clock high");
	chk_start_clk_low: assert property (
		$fell(chip_select_low) |-> !serial_clock_pin[*4])
		else $error("clock rose too soon after select");
endmodule : srs_asserts
`default_nettype wire

// File: dv/srs_test.sv
// bench: apb drives the host end, frames cross to the device end
// assumes package, interface, both ends and checker compile first
`timescale 1ns/1ps
`default_nettype none
module srs_test;
	import srs_pkg::*;
	// clock, reset and chip inputs
	logic        sys_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        por = 1'b0, wd = 1'b0, cf = 1'b0, central_overtemp_bit = 1'b0;
	logic        clr = 1'b0;
	// apb master side
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready;
	// register file beside the device, and wire monitor
	srs_addr_t   raddr;
	srs_data_t   wdata;
	srs_data_t   mem = 8'ha5;
	logic        we, ferr, sck_d;
	logic [15:0] mon_in, mon_out;
	int          errors = 0;
	int          checks_done = 0;

	srs_if link_if ();
	always #2.5 sys_clk_i = ~sys_clk_i;

	srs_device srs_device_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.por_active_i(por), .wd_reset_i(wd),
		.central_failure_bit_i(cf), .central_overtemp_bit_i(central_overtemp_bit),
		.reg_addr_o(raddr), .reg_readable_i(raddr inside {7'h05, 7'h06}),
		.reg_writable_i(raddr == 7'h05),
		.reg_rdata_i(raddr == 7'h05 ? mem : 8'h6c),
		.reg_we_o(we), .reg_wdata_o(wdata), .comm_frame_error_flag_o(ferr),
		.comm_frame_error_clr_i(clr), .link(link_if.device));
	srs_host srs_host_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(), .link(link_if.host));
	srs_asserts srs_asserts_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.por_active_i(por), .wd_reset_i(wd), .central_failure_bit_i(cf),
		.central_overtemp_bit_i(central_overtemp_bit),
		.chip_select_low(link_if.chip_select_low),
		.serial_clock_pin(link_if.serial_clock_pin),
		.serial_in_pin(link_if.serial_in_pin), .sdo_o(link_if.sdo_o),
		.sdo_oe_n(link_if.sdo_oe_n), .sdo_line(link_if.sdo_line));

	// register writes land; wire bits gathered at each falling edge
	always @(posedge sys_clk_i) begin
		sck_d <= link_if.serial_clock_pin;
		if (we === 1'b1)
			mem <= wdata;
		if (sck_d && !link_if.serial_clock_pin && !link_if.chip_select_low) begin
			mon_in  <= {link_if.serial_in_pin, mon_in[15:1]};
			mon_out <= {link_if.sdo_line, mon_out[15:1]};
		end
	end

	// counts and verdict, then stop
	task results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// compare one value
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// one apb transfer, waits for pready under a bound
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			results();
		end
	endtask : apb

	// one frame of given length; checks flag, answer and wire bits
	task xfer(input int bits, input logic [15:0] f, input logic [15:0] exp,
		input logic fl, input bit chk);
		int n;
		n = 0;
		apb(1'b1, OFS_CFG, 32'(bits), r);
		apb(1'b1, OFS_CTRL, {15'h0, 1'b1, f}, r);
		do begin
			apb(1'b0, OFS_STATUS, 32'h0, r);
			n++;
		end while (r[0] !== 1'b0 && n < 1000);
		if (r[0] !== 1'b0) begin
			errors++;
			results();
		end
		// let the device see select rise and settle its next answer
		repeat (12) @(posedge sys_clk_i);
		if (chk) begin
			cmp({31'h0, r[1]}, {31'h0, fl});
			apb(1'b0, OFS_RX, 32'h0, r);
			cmp({16'h0, r[15:0]}, {16'h0, exp});
			cmp({16'h0, mon_in}, {16'h0, f});
			cmp({16'h0, mon_out}, {16'h0, exp});
		end
		$display("frame %h of %0d bits done", f, bits);
	endtask : xfer

	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		apb(1'b1, 12'h010, 32'h1000a, r);
		xfer(16, 16'h000a, 16'h0002, 1'b0, 1);
		xfer(16, 16'h5a0b, 16'ha50a, 1'b0, 1);
		xfer(16, 16'h000c, 16'h5a0b, 1'b0, 1);
		cmp({24'h0, mem}, 32'h5a);
		xfer(16, 16'hff0d, 16'h6c0c, 1'b0, 1);
		xfer(16, 16'h000e, 16'h000d, 1'b0, 1);
		cf <= 1'b1;
		xfer(16, 16'h000a, 16'h000e, 1'b1, 1);
		cf <= 1'b0;
		xfer(15, 16'h000a, 16'h0, 1'b0, 0);
		cmp({31'h0, ferr}, 32'h1);
		xfer(17, 16'h000a, 16'h0, 1'b0, 0);
		central_overtemp_bit <= 1'b1;
		xfer(16, 16'h000a, 16'h0006, 1'b1, 1);
		central_overtemp_bit <= 1'b0;
		cmp({31'h0, ferr}, 32'h1);
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		@(posedge sys_clk_i);
		cmp({31'h0, ferr}, 32'h0);
		wd <= 1'b1;
		xfer(16, 16'h110b, 16'h0, 1'b0, 0);
		wd <= 1'b0;
		xfer(16, 16'h000a, 16'h0004, 1'b0, 1);
		xfer(16, 16'h000a, 16'h5a0a, 1'b0, 1);
		por <= 1'b1;
		xfer(16, 16'h110b, 16'h0, 1'b0, 0);
		por <= 1'b0;
		xfer(16, 16'h000a, 16'h0002, 1'b0, 1);
		xfer(16, 16'h000a, 16'h5a0a, 1'b0, 1);
		results();
	end
endmodule : srs_test
`default_nettype wire
